//--- src/tpgl_top.sv
// Purpose: pattern generator line timing, porches and colour bytes
// Assumes: registers written over a byte port, stream drained by the transmitter
// Notes:   tokens: frame start, line start, pixel byte, frame end
`timescale 1ns/1ps

module tpgl_top (
	input  wire logic                        ref_clk,
	input  wire logic                        rst,
	input  wire logic [tpgl_pkg::ADDR_W-1:0] regAddr,
	input  wire logic [tpgl_pkg::DATA_W-1:0] regWrData,
	input  wire logic                        regWrEn,
	input  wire logic                        regRdEn,
	output logic      [tpgl_pkg::DATA_W-1:0] regRdData,
	output logic                             outValid,
	input  wire logic                        outReady,
	output logic      [7:0]                  outData,
	output logic      [1:0]                  outKind
);
	import tpgl_pkg::*;

	logic [7:0]  ctrl_r;
	logic [1:0]  rate_r;
	logic [15:0] lineSize_r;
	logic [15:0] barSize_r;
	logic [15:0] actLines_r;
	logic [15:0] totalLines_r;
	logic [7:0]  periodHigh_r;
	logic [7:0]  periodLow_r;
	logic [7:0]  backPorch_r;
	logic [7:0]  frontPorch_r;
	logic [7:0]  barColour0_r;
	logic [7:0]  barColour1_r;
	logic [7:0]  barColour2_r;

	tpgl_state_e state_r;
	logic [15:0] lineIdx_r;
	logic [15:0] bytePos_r;
	logic [15:0] barByte_r;
	logic [1:0]  barIdx_r;
	logic [1:0]  fixIdx_r;

	logic        genEn;
	logic        fixedSel;
	logic [15:0] linePeriod;
	logic        lineTick;
	logic [15:0] totalEff;
	logic [17:0] actEnd;
	logic [17:0] feLine;
	logic [15:0] feLineClip;
	logic [15:0] nextIdx;
	logic        srcValid;
	logic        srcReady;
	logic        srcTake;
	logic [1:0]  srcKind;
	logic [7:0]  srcData;
	logic        lastByte;

	function automatic logic [7:0] pickColour(input logic [1:0] idx, input logic [7:0] c0,
			input logic [7:0] c1, input logic [7:0] c2);
		unique case (idx)
			2'h0:    pickColour = c0;
			2'h1:    pickColour = c1;
			default: pickColour = c2;
		endcase
	endfunction

	function automatic logic isActive(input logic [15:0] idx, input logic [7:0] vbp,
			input logic [17:0] aEnd, input logic [15:0] fe);
		isActive = (idx >= 16'(vbp)) && (18'(idx) < aEnd) && (idx < fe);
	endfunction

	assign genEn      = ctrl_r[CTRL_EN_BIT];
	assign fixedSel   = ctrl_r[CTRL_FIXED_BIT];
	assign linePeriod = {periodHigh_r, periodLow_r};
	assign totalEff   = (totalLines_r == 16'h0000) ? 16'h0001 : totalLines_r;
	assign actEnd     = 18'(backPorch_r) + 18'(actLines_r);
	assign feLine     = actEnd + 18'(frontPorch_r);
	assign feLineClip = (feLine >= 18'(totalEff)) ? totalEff - 16'h0001 : feLine[15:0];
	assign nextIdx    = (lineIdx_r + 16'h0001 >= totalEff) ? 16'h0000 : lineIdx_r + 16'h0001;

	// register writes
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ctrl_r       <= RST_CTRL;
			rate_r       <= RST_RATE;
			lineSize_r   <= RST_LINE_SIZE;
			barSize_r    <= RST_BAR_SIZE;
			actLines_r   <= RST_ACT_LINES;
			totalLines_r <= RST_TOTAL_LINES;
			periodHigh_r <= RST_PERIOD_H;
			periodLow_r  <= RST_PERIOD_L;
			backPorch_r  <= RST_BACK_PORCH;
			frontPorch_r <= RST_FRONT_PORCH;
			barColour0_r <= RST_COLOUR0;
			barColour1_r <= RST_COLOUR1;
			barColour2_r <= RST_COLOUR2;
		end else if (regWrEn) begin
			unique case (regAddr)
				OFF_CTRL:        ctrl_r              <= regWrData;
				OFF_RATE:        rate_r              <= regWrData[1:0];
				OFF_LINE_SIZE_H: lineSize_r[15:8]    <= regWrData;
				OFF_LINE_SIZE_L: lineSize_r[7:0]     <= regWrData;
				OFF_BAR_SIZE_H:  barSize_r[15:8]     <= regWrData;
				OFF_BAR_SIZE_L:  barSize_r[7:0]      <= regWrData;
				OFF_ACT_H:       actLines_r[15:8]    <= regWrData;
				OFF_ACT_L:       actLines_r[7:0]     <= regWrData;
				OFF_TOTAL_H:     totalLines_r[15:8]  <= regWrData;
				OFF_TOTAL_L:     totalLines_r[7:0]   <= regWrData;
				OFF_PERIOD_H:    periodHigh_r        <= regWrData;
				OFF_PERIOD_L:    periodLow_r         <= regWrData;
				OFF_BACK_PORCH:  backPorch_r         <= regWrData;
				OFF_FRONT_PORCH: frontPorch_r        <= regWrData;
				OFF_COLOUR0:     barColour0_r        <= regWrData;
				OFF_COLOUR1:     barColour1_r        <= regWrData;
				OFF_COLOUR2:     barColour2_r        <= regWrData;
				default:         ;
			endcase
		end
	end

	// register reads, data one cycle after the strobe, unmapped reads zero
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			regRdData <= '0;
		end else if (regRdEn) begin
			unique case (regAddr)
				OFF_CTRL:        regRdData <= ctrl_r;
				OFF_RATE:        regRdData <= {6'h00, rate_r};
				OFF_STATUS:      regRdData <= {genEn, 4'h0, state_r};
				OFF_LINE_SIZE_H: regRdData <= lineSize_r[15:8];
				OFF_LINE_SIZE_L: regRdData <= lineSize_r[7:0];
				OFF_BAR_SIZE_H:  regRdData <= barSize_r[15:8];
				OFF_BAR_SIZE_L:  regRdData <= barSize_r[7:0];
				OFF_ACT_H:       regRdData <= actLines_r[15:8];
				OFF_ACT_L:       regRdData <= actLines_r[7:0];
				OFF_TOTAL_H:     regRdData <= totalLines_r[15:8];
				OFF_TOTAL_L:     regRdData <= totalLines_r[7:0];
				OFF_PERIOD_H:    regRdData <= periodHigh_r;
				OFF_PERIOD_L:    regRdData <= periodLow_r;
				OFF_BACK_PORCH:  regRdData <= backPorch_r;
				OFF_FRONT_PORCH: regRdData <= frontPorch_r;
				OFF_COLOUR0:     regRdData <= barColour0_r;
				OFF_COLOUR1:     regRdData <= barColour1_r;
				OFF_COLOUR2:     regRdData <= barColour2_r;
				default:         regRdData <= '0;
			endcase
		end
	end

	tpgl_line_timer u_timer (
		.ref_clk    (ref_clk),
		.rst        (rst),
		.restart    (!genEn || state_r == ST_IDLE),
		.linePeriod (linePeriod),
		.rate       (rate_r),
		.lineTick   (lineTick)
	);

	// token source
	always_comb begin
		srcValid = 1'b0;
		srcKind  = KIND_PIXEL;
		srcData  = 8'h00;
		unique case (state_r)
			ST_FS: begin
				srcValid = 1'b1;
				srcKind  = KIND_FS;
			end
			ST_FE: begin
				srcValid = 1'b1;
				srcKind  = KIND_FE;
			end
			ST_LS: begin
				srcValid = 1'b1;
				srcKind  = KIND_LS;
			end
			ST_DATA: begin
				srcValid = 1'b1;
				if (fixedSel) begin
					srcData = pickColour(fixIdx_r, barColour0_r, barColour1_r, barColour2_r);
				end else begin
					srcData = pickColour(barIdx_r, barColour0_r, barColour1_r, barColour2_r);
				end
			end
			default: ;
		endcase
	end

	assign srcTake  = srcValid && srcReady && !lineTick;
	assign lastByte = (bytePos_r + 16'h0001 >= lineSize_r);

	// line and frame sequencing
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state_r   <= ST_IDLE;
			lineIdx_r <= '0;
		end else if (!genEn) begin
			state_r   <= ST_IDLE;
			lineIdx_r <= '0;
		end else if (state_r == ST_IDLE) begin
			state_r   <= ST_FS;
			lineIdx_r <= '0;
		end else if (lineTick) begin
			lineIdx_r <= nextIdx;
			if (nextIdx == 16'h0000) begin
				state_r <= ST_FS;
			end else if (nextIdx == feLineClip) begin
				state_r <= ST_FE;
			end else if (isActive(nextIdx, backPorch_r, actEnd, feLineClip)) begin
				state_r <= ST_LS;
			end else begin
				state_r <= ST_WAIT;
			end
		end else if (srcTake) begin
			unique case (state_r)
				ST_FS:   state_r <= isActive(lineIdx_r, backPorch_r, actEnd, feLineClip) ?
				                    ST_LS : ST_WAIT;
				ST_LS:   state_r <= (lineSize_r == 16'h0000) ? ST_WAIT : ST_DATA;
				ST_DATA: state_r <= lastByte ? ST_WAIT : ST_DATA;
				ST_FE:   state_r <= ST_WAIT;
				default: ;
			endcase
		end
	end

	// byte position, bar and fixed pattern counters
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			bytePos_r <= '0;
			barByte_r <= '0;
			barIdx_r  <= '0;
			fixIdx_r  <= '0;
		end else if (srcTake && state_r == ST_LS) begin
			bytePos_r <= '0;
			barByte_r <= '0;
			barIdx_r  <= '0;
			fixIdx_r  <= '0;
		end else if (srcTake && state_r == ST_DATA) begin
			bytePos_r <= bytePos_r + 16'h0001;
			fixIdx_r  <= (fixIdx_r == 2'h2) ? 2'h0 : fixIdx_r + 2'h1;
			if (barByte_r + 16'h0001 >= barSize_r && barIdx_r != 2'h2) begin
				barByte_r <= '0;
				barIdx_r  <= barIdx_r + 2'h1;
			end else begin
				barByte_r <= barByte_r + 16'h0001;
			end
		end
	end

	tpgl_pair_buf #(
		.WIDTH (TOKEN_W),
		.DEPTH (2)
	) u_buf (
		.ref_clk  (ref_clk),
		.rst      (rst),
		.inValid  (srcValid && !lineTick),
		.inData   ({srcKind, srcData}),
		.inReady  (srcReady),
		.outValid (outValid),
		.outData  ({outKind, outData}),
		.outReady (outReady)
	);

	// checks
	logic wroteHigh_r;
	logic wroteLow_r;
	logic [16:0] barTwoStart;

	// bar 2 begins after two full bars; bars are judged by byte position
	assign barTwoStart = {barSize_r, 1'b0};

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			wroteHigh_r <= 1'b0;
			wroteLow_r  <= 1'b0;
		end else if (regWrEn) begin
			wroteHigh_r <= wroteHigh_r || (regAddr == OFF_PERIOD_H);
			wroteLow_r  <= wroteLow_r || (regAddr == OFF_PERIOD_L);
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	sequence lineStarts;
		lineTick && genEn && state_r != ST_IDLE;
	endsequence

	sequence lineRestarted;
		state_r != ST_DATA && lineIdx_r == $past(nextIdx);
	endsequence

	chk_period_reset: assert property (
		(regRdEn && !regWrEn && regAddr == OFF_PERIOD_H && !wroteHigh_r) |=> regRdData == 8'h0c)
		else $error("period high byte reset value wrong");
	chk_period_low: assert property (
		(regRdEn && !regWrEn && regAddr == OFF_PERIOD_L && !wroteLow_r) |=> regRdData == 8'h67)
		else $error("period low byte reset value wrong");
	chk_back_porch: assert property (
		(state_r == ST_LS) |-> lineIdx_r >= 16'(backPorch_r))
		else $error("video line inside back porch");
	chk_front_porch: assert property (
		(state_r == ST_FE && srcTake) |-> lineIdx_r == feLineClip)
		else $error("frame end on wrong line");
	chk_bar_zero: assert property (
		(state_r == ST_DATA && !fixedSel && barSize_r != 16'h0000 && bytePos_r < barSize_r)
			|-> srcData == barColour0_r)
		else $error("bar 0 byte wrong");
	chk_bar_one: assert property (
		(state_r == ST_DATA && !fixedSel && barSize_r != 16'h0000 && bytePos_r >= barSize_r
			&& 17'(bytePos_r) < barTwoStart) |-> srcData == barColour1_r)
		else $error("bar 1 byte wrong");
	chk_bar_two: assert property (
		(state_r == ST_DATA && !fixedSel && barSize_r != 16'h0000
			&& 17'(bytePos_r) >= barTwoStart) |-> srcData == barColour2_r)
		else $error("bar 2 byte wrong");
	chk_fixed_order: assert property (
		(srcTake && state_r == ST_DATA && fixedSel && srcData == barColour0_r && fixIdx_r == 2'h0
			&& !lastByte && $stable(ctrl_r))
			|=> (srcData == barColour1_r || lineTick || !fixedSel || !genEn))
		else $error("fixed pattern order wrong");
	chk_mode_select: assert property (
		(state_r == ST_DATA && fixedSel && bytePos_r == 16'h0000) |-> srcData == barColour0_r)
		else $error("fixed mode first byte wrong");
	chk_total_bound: assert property (
		(state_r != ST_IDLE) |-> lineIdx_r < totalEff)
		else $error("line index beyond frame total");
	chk_line_restart: assert property (
		lineStarts |=> lineRestarted)
		else $error("line did not restart on period");
endmodule

//--- src/tpgl_pkg.sv
// Purpose: shared constants for the pattern line timing and colour block
// Assumes: 20 MHz ref_clk, byte-wide register port
// Notes:   times are kept in tens of picoseconds so 13.33 ns stays exact
package tpgl_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;

	// register offsets
	localparam logic [7:0] OFF_CTRL        = 8'h02;
	localparam logic [7:0] OFF_LINE_SIZE_H = 8'h04;
	localparam logic [7:0] OFF_LINE_SIZE_L = 8'h05;
	localparam logic [7:0] OFF_BAR_SIZE_H  = 8'h06;
	localparam logic [7:0] OFF_BAR_SIZE_L  = 8'h07;
	localparam logic [7:0] OFF_ACT_H       = 8'h08;
	localparam logic [7:0] OFF_ACT_L       = 8'h09;
	localparam logic [7:0] OFF_TOTAL_H     = 8'h0a;
	localparam logic [7:0] OFF_TOTAL_L     = 8'h0b;
	localparam logic [7:0] OFF_PERIOD_H    = 8'h0c;
	localparam logic [7:0] OFF_PERIOD_L    = 8'h0d;
	localparam logic [7:0] OFF_BACK_PORCH  = 8'h0e;
	localparam logic [7:0] OFF_FRONT_PORCH = 8'h0f;
	localparam logic [7:0] OFF_COLOUR0     = 8'h10;
	localparam logic [7:0] OFF_COLOUR1     = 8'h11;
	localparam logic [7:0] OFF_COLOUR2     = 8'h12;
	localparam logic [7:0] OFF_RATE        = 8'h20;
	localparam logic [7:0] OFF_STATUS      = 8'h21;

	// control fields
	localparam int CTRL_FIXED_BIT = 7;
	localparam int CTRL_EN_BIT    = 0;

	// reset values
	localparam logic [7:0]  RST_CTRL        = 8'h00;
	localparam logic [15:0] RST_LINE_SIZE   = 16'h0780;
	localparam logic [15:0] RST_BAR_SIZE    = 16'h00f0;
	localparam logic [15:0] RST_ACT_LINES   = 16'h01e0;
	localparam logic [15:0] RST_TOTAL_LINES = 16'h020d;
	localparam logic [7:0]  RST_PERIOD_H    = 8'h0c;
	localparam logic [7:0]  RST_PERIOD_L    = 8'h67;
	localparam logic [7:0]  RST_BACK_PORCH  = 8'h00;
	localparam logic [7:0]  RST_FRONT_PORCH = 8'h00;
	localparam logic [7:0]  RST_COLOUR0     = 8'haa;
	localparam logic [7:0]  RST_COLOUR1     = 8'h33;
	localparam logic [7:0]  RST_COLOUR2     = 8'h00;

	// output rate codes
	localparam logic [1:0] RATE_400  = 2'h0;
	localparam logic [1:0] RATE_800  = 2'h1;
	localparam logic [1:0] RATE_1200 = 2'h2;
	localparam logic [1:0] RATE_1600 = 2'h3;
	localparam logic [1:0] RST_RATE  = RATE_800;

	// timing, in tens of picoseconds
	localparam int     CLK_FREQ_HZ       = 20000000;
	localparam longint TENPS_PER_SEC     = 64'd100000000000;
	localparam int     CLK_PERIOD_X10PS  = int'(TENPS_PER_SEC / CLK_FREQ_HZ);
	localparam int     UNIT_FAST_X10PS   = 1000;
	localparam int     UNIT_MID_X10PS    = 1333;
	localparam int     UNIT_SLOW_X10PS   = 2000;

	// token kinds on the output stream
	localparam logic [1:0] KIND_PIXEL = 2'h0;
	localparam logic [1:0] KIND_FS    = 2'h1;
	localparam logic [1:0] KIND_FE    = 2'h2;
	localparam logic [1:0] KIND_LS    = 2'h3;
	localparam int         TOKEN_W    = 10;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_FS   = 3'b001,
		ST_LS   = 3'b010,
		ST_DATA = 3'b011,
		ST_WAIT = 3'b100,
		ST_FE   = 3'b101
	} tpgl_state_e;

	function automatic logic [31:0] unitTime(input logic [1:0] rate);
		unique case (rate)
			RATE_800, RATE_1600: unitTime = 32'(UNIT_FAST_X10PS);
			RATE_1200:           unitTime = 32'(UNIT_MID_X10PS);
			RATE_400:            unitTime = 32'(UNIT_SLOW_X10PS);
		endcase
	endfunction

endpackage

//--- src/tpgl_pair_buf.sv
// Purpose: small valid/ready buffer in the output path
// Assumes: single clock
// Notes:   inReady drops when full, which stalls the generator
`timescale 1ns/1ps
module tpgl_pair_buf #(
	parameter int WIDTH = 10,
	parameter int DEPTH = 2
) (
	input  wire logic             ref_clk,
	input  wire logic             rst,
	input  wire logic             inValid,
	input  wire logic [WIDTH-1:0] inData,
	output logic                  inReady,
	output logic                  outValid,
	output logic      [WIDTH-1:0] outData,
	input  wire logic             outReady
);
	localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CNT_W = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PTR_W-1:0] wrPtr_r;
	logic [PTR_W-1:0] rdPtr_r;
	logic [CNT_W-1:0] count_r;
	logic             push;
	logic             pop;

	assign inReady  = (count_r != CNT_W'(DEPTH));
	assign outValid = (count_r != '0);
	assign outData  = mem[rdPtr_r];
	assign push     = inValid && inReady;
	assign pop      = outValid && outReady;

	always_ff @(posedge ref_clk) begin
		if (push) begin
			mem[wrPtr_r] <= inData;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			wrPtr_r <= '0;
			rdPtr_r <= '0;
			count_r <= '0;
		end else begin
			if (push) begin
				wrPtr_r <= (wrPtr_r == PTR_W'(DEPTH - 1)) ? '0 : wrPtr_r + 1'b1;
			end
			if (pop) begin
				rdPtr_r <= (rdPtr_r == PTR_W'(DEPTH - 1)) ? '0 : rdPtr_r + 1'b1;
			end
			count_r <= count_r + CNT_W'(push) - CNT_W'(pop);
		end
	end
endmodule

//--- src/tpgl_line_timer.sv
// Purpose: line period timer with rate dependent count unit
// Assumes: period and rate from registers on the same clock
// Notes:   the remainder carries into the next line so the average is exact
`timescale 1ns/1ps
module tpgl_line_timer (
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire logic        restart,
	input  wire logic [15:0] linePeriod,
	input  wire logic [1:0]  rate,
	output logic             lineTick
);
	import tpgl_pkg::*;

	localparam logic [31:0] CLK_STEP = 32'(CLK_PERIOD_X10PS);

	logic [31:0] elapsed_r;
	logic [31:0] target;
	logic [15:0] periodEff;
	logic [15:0] sinceTick_r;
	logic        cleanLine_r;

	assign periodEff = (linePeriod == 16'h0000) ? 16'h0001 : linePeriod;
	assign target    = 32'(periodEff * unitTime(rate));
	assign lineTick  = !restart && (elapsed_r + CLK_STEP >= target);

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			elapsed_r <= '0;
		end else if (restart) begin
			elapsed_r <= '0;
		end else if (lineTick && elapsed_r >= target) begin
			// period shrank mid-line: start clean rather than tick again at once
			elapsed_r <= '0;
		end else if (lineTick) begin
			elapsed_r <= elapsed_r + CLK_STEP - target;
		end else begin
			elapsed_r <= elapsed_r + CLK_STEP;
		end
	end

	// helper for the spacing check
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			sinceTick_r <= '0;
			cleanLine_r <= 1'b0;
		end else begin
			sinceTick_r <= lineTick ? 16'h0001 : sinceTick_r + 16'h0001;
			if (restart || !$stable(linePeriod) || !$stable(rate)) begin
				cleanLine_r <= 1'b0;
			end else if (lineTick) begin
				cleanLine_r <= 1'b1;
			end
		end
	end

	chk_line_spacing: assert property (@(posedge ref_clk) disable iff (rst)
		(lineTick && cleanLine_r) |->
			(32'(sinceTick_r) >= target / CLK_STEP) && (32'(sinceTick_r) <= target / CLK_STEP + 1))
		else $error("line period spacing off");
endmodule

//--- tb/tpgl_csi_sink.sv
// Purpose: stream consumer standing in for the CSI-2 transmitter
// Assumes: single clock, ready driven right after the rising edge
// Notes:   when stalling it drops ready at random and in bursts of four,
//          bursts start only while a token waits so the buffer fills up
`timescale 1ns/1ps
module tpgl_csi_sink (
	input  wire logic ref_clk,
	input  wire logic rst,
	input  wire logic stallOn,
	input  wire logic outValid,
	output logic      outReady
);
	int burst;

	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			outReady <= 1'b1;
			burst    <= 0;
		end else if (!stallOn) begin
			outReady <= 1'b1;
		end else if (burst > 0) begin
			burst    <= burst - 1;
			outReady <= 1'b0;
		end else if (outValid && $urandom_range(9) == 0) begin
			burst    <= 3;
			outReady <= 1'b0;
		end else begin
			outReady <= ($urandom_range(3) != 0);
		end
	end
endmodule

//--- tb/tb_top.sv
// Purpose: self-checking bench for the pattern line timing and colour block
// Assumes: 20 MHz ref_clk, byte register port, fixed random seed
// Notes:   line timing is judged only on frames run without consumer stalls
`timescale 1ns/1ps
module tb_top;
	import tpgl_pkg::*;
	logic              ref_clk   = 1'b0;
	logic              rst       = 1'b1;
	logic [ADDR_W-1:0] regAddr   = '0;
	logic [DATA_W-1:0] regWrData = '0;
	logic              regWrEn   = 1'b0;
	logic              regRdEn   = 1'b0;
	logic [DATA_W-1:0] regRdData;
	logic              outValid;
	logic              outReady;
	logic [7:0]        outData;
	logic [1:0]        outKind;
	logic              stallOn   = 1'b0;
	int                errorCnt  = 0;
	int                nChecks   = 0;
	int                cyc       = 0;
	logic [7:0]        tkData[$];
	logic [1:0]        tkKind[$];
	int                tkCyc[$];
	logic [7:0]        wrVal[7];

	always #25 ref_clk = ~ref_clk;

	tpgl_top i_tpgl_top (.ref_clk(ref_clk), .rst(rst), .regAddr(regAddr),
		.regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
		.regRdData(regRdData), .outValid(outValid), .outReady(outReady),
		.outData(outData), .outKind(outKind));

	tpgl_csi_sink i_tpgl_csi_sink (.ref_clk(ref_clk), .rst(rst), .stallOn(stallOn),
		.outValid(outValid), .outReady(outReady));

	// record every token at the edge where it is taken
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (outValid === 1'b1 && outReady === 1'b1) begin
			tkData.push_back(outData);
			tkKind.push_back(outKind);
			tkCyc.push_back(cyc);
		end
	end

	task automatic results();
		$display("checks %0d mismatches %0d", nChecks, errorCnt);
		if (errorCnt == 0 && nChecks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		nChecks++;
		if (got !== exp) begin
			errorCnt++;
			$display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic near(input int got, input real exp, input string what);
		nChecks++;
		if (real'(got) > exp + 2.0 || real'(got) < exp - 2.0) begin
			errorCnt++;
			$display("unexpected at %0t: %s took %0d cycles, expected %0.1f", $time, what, got, exp);
		end
	endtask

	function automatic real unitNs(input logic [1:0] rate);
		return (rate == RATE_400) ? 20.0 : (rate == RATE_1200) ? 13.33 : 10.0;
	endfunction

	// bars are two bytes wide here, bar 2 takes the rest of the line
	function automatic logic [7:0] expByte(input logic fix, input int i,
		input logic [7:0] c0, input logic [7:0] c1, input logic [7:0] c2);
		int s;
		s = fix ? i % 3 : (i < 2 ? 0 : (i < 4 ? 1 : 2));
		return (s == 0) ? c0 : (s == 1) ? c1 : c2;
	endfunction

	task automatic regWr(input logic [7:0] a, input logic [7:0] d);
		regAddr   <= a;
		regWrData <= d;
		regWrEn   <= 1'b1;
		regRdEn   <= 1'b0;
		@(posedge ref_clk);
	endtask

	task automatic regIdle();
		regWrEn <= 1'b0;
		regRdEn <= 1'b0;
	endtask

	task automatic regRd(input logic [7:0] a, input logic [7:0] exp);
		regAddr <= a;
		regRdEn <= 1'b1;
		regWrEn <= 1'b0;
		@(posedge ref_clk);
		regRdEn <= 1'b0;
		@(negedge ref_clk);
		chk(regRdData, exp, "register read");
		@(posedge ref_clk);
	endtask

	task automatic runFrame(input logic fix, input logic [1:0] rate, input logic [15:0] per,
		input logic [7:0] vbp, input logic [7:0] vfp, input int act, input int total,
		input logic stall);
		logic [7:0] col[3];
		logic [1:0] ek;
		int         i;
		int         j;
		int         n;
		int         lenL;
		int         feLine;
		real        lc;
		lenL = fix ? 6 : 7;
		for (i = 0; i < 3; i++) col[i] = 8'($urandom);
		stallOn <= stall;
		regWr(OFF_RATE, {6'h00, rate});
		regWr(OFF_PERIOD_H, per[15:8]);
		regWr(OFF_PERIOD_L, per[7:0]);
		regWr(OFF_BACK_PORCH, vbp);
		regWr(OFF_FRONT_PORCH, vfp);
		regWr(OFF_LINE_SIZE_H, 8'h00);
		regWr(OFF_LINE_SIZE_L, 8'(lenL));
		regWr(OFF_BAR_SIZE_H, 8'h00);
		regWr(OFF_BAR_SIZE_L, 8'h02);
		regWr(OFF_ACT_H, 8'h00);
		regWr(OFF_ACT_L, 8'(act));
		regWr(OFF_TOTAL_H, 8'h00);
		regWr(OFF_TOTAL_L, 8'(total));
		for (i = 0; i < 3; i++) regWr(8'(OFF_COLOUR0 + i), col[i]);
		tkKind.delete();
		tkData.delete();
		tkCyc.delete();
		regWr(OFF_CTRL, {fix, 7'h01});
		regIdle();
		n = 0;
		while (n < 3000 && !(tkKind.size() > 0 && tkKind[$] === KIND_FE)) begin
			@(posedge ref_clk);
			n++;
		end
		if (n >= 3000) begin
			errorCnt++;
			$display("unexpected at %0t: frame end never came", $time);
		end
		regWr(OFF_CTRL, 8'h00);
		regIdle();
		@(posedge ref_clk);
		chk(8'(tkKind.size()), 8'(act * (lenL + 1) + 2), "token count");
		if (tkKind.size() == act * (lenL + 1) + 2) begin
			for (i = 0; i < tkKind.size(); i++) begin
				j = (i - 1) % (lenL + 1);
				ek = (i == 0) ? KIND_FS : (i == tkKind.size() - 1) ? KIND_FE :
					(j == 0) ? KIND_LS : KIND_PIXEL;
				chk({6'h00, tkKind[i]}, {6'h00, ek}, "token kind");
				if (ek == KIND_PIXEL) begin
					chk(tkData[i], expByte(fix, j - 1, col[0], col[1], col[2]), "pixel");
				end
			end
			if (!stall) begin
				lc = real'(per) * unitNs(rate) / 50.0;
				feLine = (vbp + act + vfp < total - 1) ? vbp + act + vfp : total - 1;
				near(tkCyc[1] - tkCyc[0], vbp * lc, "back porch");
				for (i = 1; i < act; i++) begin
					near(tkCyc[1 + i * (lenL + 1)] - tkCyc[1 + (i - 1) * (lenL + 1)], lc, "line");
				end
				near(tkCyc[tkCyc.size() - 1] - tkCyc[0], feLine * lc, "frame end");
			end
		end
	endtask

	initial begin
		repeat (20000) @(posedge ref_clk);
		errorCnt++;
		$display("unexpected at %0t: run did not finish in time", $time);
		results();
	end

	initial begin
		void'($urandom(80579));
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		regRd(OFF_PERIOD_H, 8'h0c);
		regRd(OFF_PERIOD_L, 8'h67);
		regRd(OFF_COLOUR0, 8'haa);
		regRd(OFF_COLOUR1, 8'h33);
		regRd(8'h30, 8'h00);
		$display("test reset values done");
		for (int k = 0; k < 7; k++) begin
			wrVal[k] = 8'($urandom);
			regWr(8'(OFF_PERIOD_H + k), wrVal[k]);
		end
		for (int k = 0; k < 7; k++) regRd(8'(OFF_PERIOD_H + k), wrVal[k]);
		$display("test register access done");
		for (int k = 0; k < 4; k++) begin
			runFrame(1'b0, 2'(k), 16'(50 + $urandom_range(20)), 8'($urandom_range(3)),
				8'($urandom_range(3)), 3, 12, 1'b0);
		end
		$display("test bar frames at every rate done");
		runFrame(1'b1, RATE_800, 16'h00c8, 8'h01, 8'h01, 3, 8, 1'b1);
		$display("test fixed frame with stalls done");
		runFrame(1'b0, RATE_1600, 16'h0040, 8'h01, 8'h06, 2, 5, 1'b0);
		$display("test front porch clipping done");
		results();
	end
endmodule
